/* verilog/edo_fpm_dram_cycle_timing.sv */
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "dram_timing_cfg.svh"
// Overview of operation
// - Read latency counts from detected address strobe to returned burst ready.
// - Host writes post at 3-1-1-1 whenever a buffer entry is free.
// - Retire leadoff counts from first burst ready to column strobe.
// - Fast EDO and speculative disable each remove one clock from read leadoff, except on pipelined page hits.
// - Leadoff base field shifts miss leadoffs only, never page hits.
// - Row miss with page still open adds two clocks to leadoff.
// - EDO four rows reads: 5-2-2-2, 8-2-2-2, 11-2-2-2; slower beat otherwise.
// - EDO back-to-back page hit reads run 5-2-2-2-3-2-2-2.
// - Fast page mode page miss reads run 12-3-3-3 or 12-4-4-4.
// - Fast page mode back-to-back page hit reads run 6-3-3-3-3-3-3-3.
// - Buffered writes retire at -2-2-2, or -3-3-3 with more rows.
// - Empty buffer retire leadoff is 3, 6 or 9 clocks.
// - Fast EDO leadoff pulls in one clock on all EDO read kinds except pipelined page hits, where it adds one.
module edo_fpm_dram_cycle_timing
  import dram_timing_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter logic [2:0] BURST_BEATS = 3'h4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic address_strobe_n,
  input wire logic host_write,
  input wire logic [1:0] access_kind,
  input wire logic prev_page_open,
  output logic burst_ready_n,
  output logic column_strobe_n
);
  logic [7:0] dram_timing_options;
  logic [7:0] dram_timing_counts;
  logic [7:0] memory_type_config;
  logic edo, speculative_leadoff_disable, fast_edo_leadoff, fast_edo_leadoff_eff;
  logic [1:0] read_burst_timing_field, write_burst_timing_field, leadoff_base_field;
  logic [3:0] rd_beat, wr_beat;
  logic [4:0] pin_s1, pin_s2, pin_s3;
  logic strobe_lvl, strobe_fall;
  logic pend, pend_write, pend_open;
  logic [1:0] pend_kind;
  host_state_t hstate;
  retire_state_t rstate;
  logic host_start, start_write, start_open, start_pipe;
  logic [1:0] start_kind;
  logic [3:0] start_lead, hcnt, cur_beat, last_lead, rcnt, ret_lead;
  logic [2:0] hleft, rleft;
  logic first, cur_write, cur_open, hold_write;
  logic [1:0] cur_kind;
  logic push_valid, push_ready, buf_valid, buf_open, ret_pop;
  logic [1:0] buf_kind, buf_level;
  logic sel_opt, sel_cnt, sel_cfg, sel_stat, addr_hit, wr_en;
  logic [7:0] rd_mux;

  function automatic logic [3:0] beat_f(input logic [3:0] ref_v, input logic [1:0] f);
    logic [3:0] v;
    v = ref_v - {2'h0, f};
    if (v == 4'h0) v = 4'h1;
    return v;
  endfunction

  function automatic logic [3:0] lead_f(input logic [1:0] kind, input logic open_row,
      input logic wr, input logic pipe, input logic fe, input logic sl,
      input logic [1:0] dl, input logic [3:0] beat);
    logic [4:0] v;
    v = wr ? `WR_HIT_LEAD : `RD_HIT_LEAD;
    if (kind != KIND_HIT) begin
      v = v + ((kind == KIND_ROW_MISS) ? `MISS_STEP : (`MISS_STEP + `MISS_STEP));
      v = v + `DLT_REF - {3'h0, dl};
      if (kind == KIND_ROW_MISS && open_row) v = v + `OPEN_ROW_ADD;
    end
    if (!wr) begin
      if (fe) v = v - 5'h01;
      if (sl) v = v - 5'h01;
      // One idle cycle splits bursts, so the beat gap is one more than this
      if (pipe && kind == KIND_HIT) v = {1'h0, beat} + {4'h0, fe} - 5'h01;
    end
    if (v < `MIN_LEAD) v = `MIN_LEAD;
    return v[3:0];
  endfunction

  assign edo = memory_type_config[`EDO_BIT];
  assign speculative_leadoff_disable = dram_timing_options[`SLD_BIT];
  assign fast_edo_leadoff = dram_timing_options[`FAST_EDO_LEADOFF_BIT];
  // Trim is ignored on fast page mode parts even if software sets it
  assign fast_edo_leadoff_eff = fast_edo_leadoff && edo;
  assign read_burst_timing_field = dram_timing_counts[`READ_BURST_TIMING_FIELD_LSB +: 2];
  assign write_burst_timing_field = dram_timing_counts[`WRITE_BURST_TIMING_FIELD_LSB +: 2];
  assign leadoff_base_field = dram_timing_counts[`DLT_LSB +: 2];
  assign rd_beat = beat_f(edo ? `RD_BEAT_EDO : `RD_BEAT_FPM, read_burst_timing_field);
  assign wr_beat = beat_f(`WR_BEAT_REF, write_burst_timing_field);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= `PIN_RST;
      pin_s2 <= `PIN_RST;
      pin_s3 <= `PIN_RST;
      strobe_lvl <= 1'b1;
    end else begin
      pin_s1 <= {address_strobe_n, host_write, prev_page_open, access_kind};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2[`PIN_STB] == pin_s3[`PIN_STB]) strobe_lvl <= pin_s3[`PIN_STB];
    end
  end

  // Latency is counted from the cycle the strobe edge is confirmed
  assign strobe_fall = strobe_lvl && (pin_s2[`PIN_STB] == pin_s3[`PIN_STB]) &&
    !pin_s3[`PIN_STB];

  // A strobe seen during a burst is held so pipelined cycles are not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 1'b0;
      pend_write <= 1'b0;
      pend_open <= 1'b0;
      pend_kind <= KIND_HIT;
    end else if (strobe_fall && (hstate != HOST_IDLE || pend)) begin
      pend <= 1'b1;
      pend_write <= pin_s3[`PIN_WR];
      pend_open <= pin_s3[`PIN_OPEN];
      pend_kind <= pin_s3[`PIN_KIND_LSB +: 2];
    end else if (host_start) begin
      pend <= 1'b0;
    end
  end

  assign host_start = (hstate == HOST_IDLE) && (pend || strobe_fall);
  assign start_write = pend ? pend_write : pin_s3[`PIN_WR];
  assign start_open = pend ? pend_open : pin_s3[`PIN_OPEN];
  assign start_kind = pend ? pend_kind : pin_s3[`PIN_KIND_LSB +: 2];
  assign start_pipe = pend && !cur_write && !start_write;
  assign start_lead = start_write ? `POST_LEAD :
    lead_f(start_kind, start_open, 1'b0, start_pipe, fast_edo_leadoff_eff, speculative_leadoff_disable, leadoff_base_field, rd_beat);
  assign cur_beat = cur_write ? `POST_BEAT : rd_beat;
  assign hold_write = first && cur_write && !push_ready;
  assign push_valid = (hstate == HOST_XFER) && (hleft != 3'h0) && (hcnt == 4'h1) &&
    first && cur_write;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hstate <= HOST_IDLE;
      hcnt <= 4'h0;
      hleft <= 3'h0;
      first <= 1'b0;
      cur_write <= 1'b1;
      cur_open <= 1'b0;
      cur_kind <= KIND_HIT;
      last_lead <= 4'h0;
      burst_ready_n <= 1'b1;
    end else begin
      unique case (hstate)
        HOST_IDLE: begin
          burst_ready_n <= 1'b1;
          if (host_start) begin
            hstate <= HOST_XFER;
            hcnt <= start_lead - 4'h1;
            hleft <= BURST_BEATS;
            first <= 1'b1;
            cur_write <= start_write;
            cur_open <= start_open;
            cur_kind <= start_kind;
            if (!start_write) last_lead <= start_lead;
          end
        end
        HOST_XFER: begin
          if (hleft == 3'h0) begin
            burst_ready_n <= 1'b1;
            hstate <= HOST_IDLE;
          end else if (hcnt == 4'h1 && !hold_write) begin
            burst_ready_n <= 1'b0;
            hcnt <= cur_beat;
            hleft <= hleft - 3'h1;
            first <= 1'b0;
          end else begin
            burst_ready_n <= 1'b1;
            if (hcnt != 4'h1) hcnt <= hcnt - 4'h1;
          end
        end
      endcase
    end
  end

  post_buffer #(.WIDTH(3), .DEPTH(2)) write_buf (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data({cur_open, cur_kind}),
    .out_valid(buf_valid),
    .out_ready(rstate == RET_IDLE),
    .out_data({buf_open, buf_kind}),
    .level(buf_level)
  );

  assign ret_pop = (rstate == RET_IDLE) && buf_valid;
  assign ret_lead = lead_f(buf_kind, buf_open, 1'b1, 1'b0, 1'b0, 1'b0, leadoff_base_field, wr_beat);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rstate <= RET_IDLE;
      rcnt <= 4'h0;
      rleft <= 3'h0;
      column_strobe_n <= 1'b1;
    end else begin
      unique case (rstate)
        RET_IDLE: begin
          column_strobe_n <= 1'b1;
          if (ret_pop) begin
            rstate <= RET_RUN;
            rcnt <= ret_lead - 4'h1;
            rleft <= BURST_BEATS;
          end
        end
        RET_RUN: begin
          if (rleft == 3'h0) begin
            column_strobe_n <= 1'b1;
            rstate <= RET_IDLE;
          end else if (rcnt == 4'h1) begin
            column_strobe_n <= 1'b0;
            rcnt <= wr_beat;
            rleft <= rleft - 3'h1;
          end else begin
            column_strobe_n <= 1'b1;
            rcnt <= rcnt - 4'h1;
          end
        end
      endcase
    end
  end

  assign sel_opt = (paddr[ADDR_W-1:2] == (ADDR_W-2)'(`REG_OPT_IDX));
  assign sel_cnt = (paddr[ADDR_W-1:2] == (ADDR_W-2)'(`REG_CNT_IDX));
  assign sel_cfg = (paddr[ADDR_W-1:2] == (ADDR_W-2)'(`REG_CFG_IDX));
  assign sel_stat = (paddr[ADDR_W-1:2] == (ADDR_W-2)'(`REG_STAT_IDX));
  assign addr_hit = (paddr[1:0] == 2'h0) && (sel_opt || sel_cnt || sel_cfg || sel_stat);
  assign wr_en = psel && penable && pready && pwrite && !pslverr && pstrb[0];

  always_comb begin
    rd_mux = 8'h00;
    if (sel_opt) rd_mux = dram_timing_options;
    if (sel_cnt) rd_mux = dram_timing_counts;
    if (sel_cfg) rd_mux = memory_type_config;
    if (sel_stat) rd_mux = {last_lead, rstate == RET_RUN, hstate == HOST_XFER, buf_level};
  end

  // Zero wait state: read data and error are settled during the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        prdata <= {24'h00_0000, rd_mux};
        pslverr <= !addr_hit;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dram_timing_options <= `OPT_RST;
      dram_timing_counts <= `CNT_RST;
      memory_type_config <= `CFG_RST;
    end else if (wr_en) begin
      if (sel_opt) dram_timing_options <= pwdata[7:0];
      if (sel_cnt) dram_timing_counts <= pwdata[7:0];
      if (sel_cfg) memory_type_config <= pwdata[7:0];
    end
  end

  a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    hstate == HOST_IDLE |-> burst_ready_n)
    else $error("burst ready active while host side idle");
  a_post_cadence: assert property (@(posedge pclk) disable iff (!presetn)
    host_start && start_write && buf_level == 2'h0 |->
    burst_ready_n [*3] ##1 !burst_ready_n [*4])
    else $error("posted write not 3-1-1-1");
  a_full_hold: assert property (@(posedge pclk) disable iff (!presetn)
    push_valid && !push_ready |=> burst_ready_n)
    else $error("write accepted with full buffer");
  a_edo_hit: assert property (@(posedge pclk) disable iff (!presetn)
    host_start && !start_write && !start_pipe && start_kind == KIND_HIT && edo && fast_edo_leadoff &&
    !speculative_leadoff_disable |-> start_lead == 4'h5)
    else $error("EDO page hit leadoff not 5");
  a_fpm_miss: assert property (@(posedge pclk) disable iff (!presetn)
    host_start && !start_write && start_kind == KIND_PAGE_MISS && !edo && !speculative_leadoff_disable &&
    leadoff_base_field == 2'h1 |-> start_lead == 4'hC)
    else $error("FPM page miss leadoff not 12");
  a_open_row: assert property (@(posedge pclk) disable iff (!presetn)
    host_start && !start_write && start_kind == KIND_ROW_MISS && start_open && fast_edo_leadoff_eff &&
    !speculative_leadoff_disable && leadoff_base_field == 2'h1 |-> start_lead == 4'hA)
    else $error("open row miss not two clocks longer");
  a_fast_edo_leadoff_trim: assert property (@(posedge pclk) disable iff (!presetn)
    host_start && !start_write && start_kind == KIND_PAGE_MISS && fast_edo_leadoff_eff && !speculative_leadoff_disable &&
    leadoff_base_field == 2'h1 |-> start_lead == 4'hB)
    else $error("fast EDO trim not one clock");
  a_read_beat: assert property (@(posedge pclk) disable iff (!presetn)
    hstate == HOST_XFER && !cur_write && !burst_ready_n && hleft != 3'h0 && edo &&
    read_burst_timing_field == 2'h2 |=> burst_ready_n ##1 !burst_ready_n)
    else $error("EDO read beat not 2 clocks");
  a_pipe_hit: assert property (@(posedge pclk) disable iff (!presetn)
    host_start && start_pipe && start_kind == KIND_HIT && read_burst_timing_field == 2'h2 &&
    (fast_edo_leadoff_eff || !edo) |-> start_lead == 4'h2)
    else $error("pipelined page hit leadoff not 2");
  a_retire_lead: assert property (@(posedge pclk) disable iff (!presetn)
    ret_pop && buf_kind == KIND_HIT |-> column_strobe_n [*3] ##1 !column_strobe_n)
    else $error("retire page hit leadoff not 3");
  a_retire_beat: assert property (@(posedge pclk) disable iff (!presetn)
    rstate == RET_RUN && !column_strobe_n && rleft != 3'h0 && write_burst_timing_field == 2'h2 |=>
    column_strobe_n ##1 !column_strobe_n)
    else $error("retire beat not 2 clocks");
endmodule
`default_nettype wire

/* verilog/dram_timing_cfg.svh */
`ifndef DRAM_TIMING_CFG_SVH
`define DRAM_TIMING_CFG_SVH
`define REG_CFG_IDX 10'h050
`define REG_STAT_IDX 10'h051
`define REG_OPT_IDX 10'h056
`define REG_CNT_IDX 10'h058
`define OPT_RST 8'h00
`define CNT_RST 8'h51
`define CFG_RST 8'h01
`define EDO_BIT 0
`define SLD_BIT 4
`define FAST_EDO_LEADOFF_BIT 5
`define READ_BURST_TIMING_FIELD_LSB 5
`define WRITE_BURST_TIMING_FIELD_LSB 3
`define DLT_LSB 0
`define PIN_RST 5'h10
`define PIN_STB 4
`define PIN_WR 3
`define PIN_OPEN 2
`define PIN_KIND_LSB 0
`define RD_HIT_LEAD 5'h06
`define WR_HIT_LEAD 5'h03
`define MISS_STEP 5'h03
`define DLT_REF 5'h01
`define OPEN_ROW_ADD 5'h02
`define MIN_LEAD 5'h02
`define POST_LEAD 4'h3
`define POST_BEAT 4'h1
`define RD_BEAT_EDO 4'h4
`define RD_BEAT_FPM 4'h5
`define WR_BEAT_REF 4'h4
`endif

/* verilog/dram_timing_pkg.sv */
package dram_timing_pkg;
  typedef enum logic [1:0] {
    KIND_HIT = 2'h0,
    KIND_ROW_MISS = 2'h1,
    KIND_PAGE_MISS = 2'h2
  } access_kind_t;
  typedef enum logic {HOST_IDLE = 1'h0, HOST_XFER = 1'h1} host_state_t;
  typedef enum logic {RET_IDLE = 1'h0, RET_RUN = 1'h1} retire_state_t;
endpackage

/* verilog/post_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
module post_buffer #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (level != ($clog2(DEPTH+1))'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/host_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input wire logic pclk,
  input wire logic presetn,
  output logic address_strobe_n,
  output logic host_write,
  output logic [1:0] access_kind,
  output logic prev_page_open,
  input wire logic burst_ready_n,
  input wire logic column_strobe_n
);
  int cyc = 0;
  logic last_as = 1'b1;
  int stb_q[$];
  int burst_ready_n_q[$];
  int cas_q[$];
  initial begin
    address_strobe_n = 1'b1;
    host_write = 1'b0;
    access_kind = 2'h0;
    prev_page_open = 1'b0;
  end
  // One edge counter for all three logs, so leadoffs and gaps subtract directly
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    last_as <= address_strobe_n;
    if (presetn && !address_strobe_n && last_as) stb_q.push_back(cyc);
    if (presetn && !burst_ready_n) burst_ready_n_q.push_back(cyc);
    if (presetn && !column_strobe_n) cas_q.push_back(cyc);
  end
  // Low for two edges so both late sync stages see it; called just after an edge
  task automatic start(input logic wr, input logic [1:0] kind, input logic open);
    address_strobe_n <= 1'b0;
    host_write <= wr;
    access_kind <= kind;
    prev_page_open <= open;
    repeat (2) @(posedge pclk);
    address_strobe_n <= 1'b1;
  endtask
  // Qualifiers are only promised until the first beat; afterwards they carry garbage
  task automatic scramble();
    host_write <= ~host_write;
    access_kind <= ~access_kind;
    prev_page_open <= ~prev_page_open;
  endtask
  task automatic clear();
    stb_q.delete();
    burst_ready_n_q.delete();
    cas_q.delete();
  endtask
endmodule
`default_nettype wire

/* testbench/edo_fpm_dram_cycle_timing_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dram_timing_cfg.svh"
module edo_fpm_dram_cycle_timing_tb;
  // Edges from first low sample of the strobe pin to the edge that counts it
  localparam int SYNC = 3;
  localparam logic [11:0] A_CFG = {`REG_CFG_IDX, 2'b00};
  localparam logic [11:0] A_OPT = {`REG_OPT_IDX, 2'b00};
  localparam logic [11:0] A_CNT = {`REG_CNT_IDX, 2'b00};
  typedef struct {
    int opt; int cnt; int cfg; int wr; int kind; int open; int lead; int beat; int wl; int wb;
  } scen_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic address_strobe_n, host_write, prev_page_open, burst_ready_n, column_strobe_n;
  logic [1:0] access_kind;
  int bad_count = 0;
  int n_compared = 0;
  int mx, lat;
  scen_t sc[$];
  edo_fpm_dram_cycle_timing edo_fpm_dram_cycle_timing_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .address_strobe_n(address_strobe_n), .host_write(host_write),
    .access_kind(access_kind), .prev_page_open(prev_page_open),
    .burst_ready_n(burst_ready_n), .column_strobe_n(column_strobe_n)
  );
  host_bus_model host_bus_model_i (
    .pclk(pclk), .presetn(presetn), .address_strobe_n(address_strobe_n),
    .host_write(host_write), .access_kind(access_kind), .prev_page_open(prev_page_open),
    .burst_ready_n(burst_ready_n), .column_strobe_n(column_strobe_n)
  );
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // One APB transfer; starts and ends just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) chk("apb ready", 32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic setup(input int cfg, input int opt, input int cnt);
    // Refresh sits outside this block, so there is none to pause around these writes
    apb(1'b1, A_CFG, 32'(cfg));
    apb(1'b1, A_OPT, 32'(opt));
    apb(1'b1, A_CNT, 32'(cnt));
    host_bus_model_i.clear();
  endtask
  task automatic wait_for(input bit cas, input int n);
    int k;
    k = 0;
    while ((cas ? host_bus_model_i.cas_q.size() : host_bus_model_i.burst_ready_n_q.size()) < n
           && k < 400) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 400) chk("event wait", 32'(n), 32'h0);
  endtask
  function automatic int bt(int i);
    return host_bus_model_i.burst_ready_n_q[i];
  endfunction
  function automatic int ct(int i);
    return host_bus_model_i.cas_q[i];
  endfunction
  function automatic void add(int o, int c, int g, int w, int k, int p, int l, int b,
                              int wl, int wb);
    sc.push_back('{o, c, g, w, k, p, l, b, wl, wb});
  endfunction
  task automatic pipe(input int cfg, input int lead, input int beat);
    setup(cfg, (cfg == 1) ? 32'h20 : 32'h00, 32'h51);
    host_bus_model_i.start(1'b0, 2'h0, 1'b0);
    wait_for(1'b0, 1);
    host_bus_model_i.start(1'b0, 2'h0, 1'b0);
    wait_for(1'b0, 8);
    chk("pipe lead", 32'(lead), 32'(bt(0) - host_bus_model_i.stb_q[0] - SYNC));
    chk("pipe gap", 32'h3, 32'(bt(4) - bt(3)));
    chk("pipe beat", 32'(beat), 32'(bt(5) - bt(4)));
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    $display("[FAIL] watchdog expected finish seen timeout");
    report_and_stop();
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_OPT, 32'h0);
    chk("options reset", 32'h00000000, rd);
    apb(1'b0, A_CNT, 32'h0);
    chk("counts reset", 32'h00000051, rd);
    apb(1'b1, A_CNT, 32'hFFFFFF6A);
    apb(1'b0, A_CNT, 32'h0);
    chk("counts readback", 32'h0000006A, rd);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    add(8'h20, 8'h51, 1, 0, 0, 0, 5, 2, 0, 0);
    add(8'h20, 8'h51, 1, 0, 1, 0, 8, 2, 0, 0);
    add(8'h20, 8'h51, 1, 0, 2, 0, 11, 2, 0, 0);
    add(8'h20, 8'h51, 1, 0, 1, 1, 10, 2, 0, 0);
    add(8'h00, 8'h51, 1, 0, 0, 0, 6, 2, 0, 0);
    add(8'h30, 8'h51, 1, 0, 2, 0, 10, 2, 0, 0);
    add(8'h20, 8'h50, 1, 0, 1, 0, 9, 2, 0, 0);
    add(8'h20, 8'h50, 1, 0, 0, 0, 5, 2, 0, 0);
    add(8'h20, 8'h29, 1, 0, 0, 0, -1, 3, 0, 0);
    add(8'h00, 8'h51, 0, 0, 2, 0, 12, 3, 0, 0);
    add(8'h00, 8'h29, 0, 0, 2, 0, 12, 4, 0, 0);
    add(8'h20, 8'h51, 1, 1, 0, 0, 3, 1, 3, 2);
    add(8'h20, 8'h51, 1, 1, 1, 0, 3, 1, 6, 2);
    add(8'h20, 8'h51, 1, 1, 2, 0, 3, 1, 9, 2);
    add(8'h20, 8'h51, 1, 1, 1, 1, 3, 1, 8, 2);
    add(8'h20, 8'h50, 1, 1, 2, 0, 3, 1, 10, 2);
    add(8'h20, 8'h29, 1, 1, 0, 0, 3, 1, 3, 3);
    foreach (sc[i]) begin
      setup(sc[i].cfg, sc[i].opt, sc[i].cnt);
      host_bus_model_i.start(1'(sc[i].wr), 2'(sc[i].kind), 1'(sc[i].open));
      wait_for(1'b0, 1);
      host_bus_model_i.scramble();
      wait_for(1'b0, 4);
      if (sc[i].wr != 0) wait_for(1'b1, 4);
      repeat (12) @(posedge pclk);
      lat = bt(0) - host_bus_model_i.stb_q[0] - SYNC;
      if (sc[i].lead >= 0) chk("leadoff", 32'(sc[i].lead), 32'(lat));
      for (int j = 1; j < 4; j++) chk("beat gap", 32'(sc[i].beat), 32'(bt(j) - bt(j - 1)));
      chk("beat count", 32'h4, 32'(host_bus_model_i.burst_ready_n_q.size()));
      chk("retire count", 32'(sc[i].wr * 4), 32'(host_bus_model_i.cas_q.size()));
      if (sc[i].wr != 0) begin
        chk("retire lead", 32'(sc[i].wl), 32'(ct(0) - bt(0)));
        for (int j = 1; j < 4; j++) chk("retire gap", 32'(sc[i].wb), 32'(ct(j) - ct(j - 1)));
      end
    end
    pipe(1, 5, 2);
    pipe(0, 6, 3);
    setup(1, 32'h20, 32'h41);
    mx = 0;
    for (int k = 0; k < 8; k++) begin
      host_bus_model_i.start(1'b1, 2'h2, 1'b0);
      wait_for(1'b0, 4 * k + 4);
      lat = bt(4 * k) - host_bus_model_i.stb_q[k] - SYNC;
      if (k == 0) chk("posted lead", 32'h3, 32'(lat));
      if (lat > mx) mx = lat;
      @(posedge pclk);
    end
    chk("full buffer stall", 32'h1, 32'(mx > 3));
    wait_for(1'b1, 32);
    repeat (30) @(posedge pclk);
    chk("all retired", 32'd32, 32'(host_bus_model_i.cas_q.size()));
    chk("slow retire gap", 32'h4, 32'(ct(1) - ct(0)));
    report_and_stop();
  end
endmodule
`default_nettype wire
